// ---- apr_bank.v ----
// Purpose: Autonegotiation page register bank behind the management pins:
//          partner base page, local next page and partner next page words
// Assumes: Arbitration logic on ref_clk delivers received pages as pulses
//          and takes the prepared next page with a one-cycle pulse
// Notes: Function
// Function
// - Partner middle word: ability bits 14,7,6,5
// - Partner middle bit 4 reports leader role
// - Low base read captures mid, high base words
// - Partner upper word: bits 14,13,12,11 abilities
// - Reset sets next page words 0x2001,0,0
// - Bit 15 request, bit 13 message encoding
// - Bit 12 writable second acknowledge flag
// - Toggle bit 11 reads zero, inserted later
// - Low eleven bits hold code, reset 1
// - Bit 14 acknowledge is read-only
// - Mid and high words writable, reset zero
// - Low next-page read captures mid, high
// - Partner next-page low word reported read-only
// - Page flag sets on store, clears on read
`timescale 1ns/100ps
`include "apr_defs.vh"

module apr_bank #(
	parameter [4:0] PORT_ADDR = 5'h00,
	parameter [1:0] TX_LEVEL_STRAP = 2'b00
) (
	input wire ref_clk,
	input wire sys_rst,
	input wire mdc,
	input wire mdioIn,
	output wire mdioOut,
	output wire mdioOe,
	input wire anRst,
	input wire rxBaseValid,
	input wire [47:0] rxBasePage,
	input wire rxNextValid,
	input wire [47:0] rxNextPage,
	input wire localAck,
	input wire txPageTaken,
	output reg [47:0] txPage,
	output reg txPageReady,
	output reg [3:0] advControl
);

	// Address match helper shared by read and write decoding
	function hit;
		input [15:0] addr;
		input [15:0] target;
		begin
			hit = (addr == target);
		end
	endfunction

	wire [15:0] regAddr;
	wire rdReq;
	wire wrReq;
	wire [15:0] wrData;
	reg [15:0] rdData_q;
	reg [15:0] rdMux;

	// Live partner words and the copies returned after a low-word read
	reg [15:0] lpBaseLow_q, lpBaseMid_q, lpBaseHigh_q;
	reg [15:0] lpBaseMidSh_q, lpBaseHighSh_q;
	reg [15:0] lpNpLow_q, lpNpMid_q, lpNpHigh_q;
	reg [15:0] lpNpMidSh_q, lpNpHighSh_q;

	// Local next page words and control
	reg [15:0] npLow_q, npMid_q, npHigh_q;
	reg [15:0] control_q;
	reg pageRx_q;
	reg ackSync_q;
	wire [15:0] npLowWr;

	// Writable bits of the low next page word; toggle and ack stay zero
	assign npLowWr = wrData & `APR_NP_LOW_WR_MASK;

	apr_mdio #(
		.PORT_ADDR(PORT_ADDR)
	) uMdio (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.mdc(mdc),
		.mdioIn(mdioIn),
		.mdioOut(mdioOut),
		.mdioOe(mdioOe),
		.regAddr(regAddr),
		.rdReq(rdReq),
		.rdData(rdData_q),
		.wrReq(wrReq),
		.wrData(wrData)
	);

	// Read multiplexer; unmapped addresses read zero
	always @* begin
		rdMux = `APR_ZERO16;
		if (hit(regAddr, `APR_ADDR_STATUS))
			rdMux[`APR_STATUS_PAGE_RX_BIT] = pageRx_q;
		if (hit(regAddr, `APR_ADDR_LP_BASE_LOW))
			rdMux = lpBaseLow_q;
		if (hit(regAddr, `APR_ADDR_LP_BASE_MID))
			rdMux = lpBaseMidSh_q;
		if (hit(regAddr, `APR_ADDR_LP_BASE_HIGH))
			rdMux = lpBaseHighSh_q;
		if (hit(regAddr, `APR_ADDR_NP_LOW)) begin
			rdMux = npLow_q;
			rdMux[`APR_NP_ACK_BIT] = ackSync_q;
		end
		if (hit(regAddr, `APR_ADDR_NP_MID))
			rdMux = npMid_q;
		if (hit(regAddr, `APR_ADDR_NP_HIGH))
			rdMux = npHigh_q;
		if (hit(regAddr, `APR_ADDR_LP_NP_LOW))
			rdMux = lpNpLow_q;
		if (hit(regAddr, `APR_ADDR_LP_NP_MID))
			rdMux = lpNpMidSh_q;
		if (hit(regAddr, `APR_ADDR_LP_NP_HIGH))
			rdMux = lpNpHighSh_q;
		if (hit(regAddr, `APR_ADDR_CONTROL))
			rdMux = control_q;
	end

	// Read data register and the acknowledge level seen by software
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			rdData_q <= `APR_ZERO16;
			ackSync_q <= 1'b0;
		end else begin
			ackSync_q <= localAck;
			if (rdReq)
				rdData_q <= rdMux;
		end
	end

	// Partner base page: store received words, copy upper words on low read
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			lpBaseLow_q <= `APR_ZERO16;
			lpBaseMid_q <= `APR_ZERO16;
			lpBaseHigh_q <= `APR_ZERO16;
			lpBaseMidSh_q <= `APR_ZERO16;
			lpBaseHighSh_q <= `APR_ZERO16;
		end else begin
			if (rxBaseValid) begin
				lpBaseLow_q <= rxBasePage[15:0] & `APR_LP_BASE_LOW_MASK;
				lpBaseMid_q <= rxBasePage[31:16] & `APR_LP_BASE_MID_MASK;
				lpBaseHigh_q <= rxBasePage[47:32] & `APR_LP_BASE_HIGH_MASK;
			end
			if (rdReq && hit(regAddr, `APR_ADDR_LP_BASE_LOW)) begin
				lpBaseMidSh_q <= lpBaseMid_q;
				lpBaseHighSh_q <= lpBaseHigh_q;
			end
		end
	end

	// Partner next page: store received words, copy upper words on low read
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			lpNpLow_q <= `APR_ZERO16;
			lpNpMid_q <= `APR_ZERO16;
			lpNpHigh_q <= `APR_ZERO16;
			lpNpMidSh_q <= `APR_ZERO16;
			lpNpHighSh_q <= `APR_ZERO16;
		end else begin
			if (rxNextValid) begin
				lpNpLow_q <= rxNextPage[15:0];
				lpNpMid_q <= rxNextPage[31:16];
				lpNpHigh_q <= rxNextPage[47:32];
			end
			if (rdReq && hit(regAddr, `APR_ADDR_LP_NP_LOW)) begin
				lpNpMidSh_q <= lpNpMid_q;
				lpNpHighSh_q <= lpNpHigh_q;
			end
		end
	end

	// Page received flag: a new page in the same cycle as the read wins
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			pageRx_q <= 1'b0;
		end else begin
			if (rxBaseValid || rxNextValid)
				pageRx_q <= 1'b1;
			else if (rdReq && hit(regAddr, `APR_ADDR_STATUS))
				pageRx_q <= 1'b0;
		end
	end

	// Local next page words; autonegotiation reset restores the null page
	always @(posedge ref_clk) begin
		if (sys_rst || anRst) begin
			npLow_q <= `APR_NP_LOW_RST;
			npMid_q <= `APR_ZERO16;
			npHigh_q <= `APR_ZERO16;
		end else if (wrReq) begin
			if (hit(regAddr, `APR_ADDR_NP_LOW))
				npLow_q <= npLowWr;
			if (hit(regAddr, `APR_ADDR_NP_MID))
				npMid_q <= wrData;
			if (hit(regAddr, `APR_ADDR_NP_HIGH))
				npHigh_q <= wrData;
		end
	end

	// Page hand-off: a low-word write freezes all three words as one page.
	// Middle and upper words must already hold their values at that point.
	always @(posedge ref_clk) begin
		if (sys_rst || anRst) begin
			txPage <= {`APR_ZERO16, `APR_ZERO16, `APR_NP_LOW_RST};
			txPageReady <= 1'b0;
		end else begin
			if (wrReq && hit(regAddr, `APR_ADDR_NP_LOW)) begin
				txPage <= {npHigh_q, npMid_q, npLowWr};
				txPageReady <= 1'b1;
			end else if (txPageTaken) begin
				txPageReady <= 1'b0;
			end
		end
	end

	// Single pair control word; bit 14 stays zero, strap bits at reset
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			control_q <= `APR_CONTROL_RST | {2'b00, TX_LEVEL_STRAP, 12'h000};
			advControl <= {2'b10, TX_LEVEL_STRAP};
		end else begin
			if (wrReq && hit(regAddr, `APR_ADDR_CONTROL)) begin
				control_q <= wrData & `APR_CONTROL_WR_MASK;
				advControl <= {wrData[15], 1'b0, wrData[13], wrData[12]};
			end
		end
	end

endmodule

// ---- apr_defs.vh ----
// Purpose: Shared constants for the autonegotiation page register bank
// Assumes: Clause 45 style management frames, 16-bit registers
// Notes: Included by the bank and the management frame engine
`ifndef APR_DEFS_VH
`define APR_DEFS_VH

// Register addresses inside the autonegotiation device
`define APR_ADDR_STATUS 16'h0201
`define APR_ADDR_LP_BASE_LOW 16'h0205
`define APR_ADDR_LP_BASE_MID 16'h0206
`define APR_ADDR_LP_BASE_HIGH 16'h0207
`define APR_ADDR_NP_LOW 16'h0208
`define APR_ADDR_NP_MID 16'h0209
`define APR_ADDR_NP_HIGH 16'h020A
`define APR_ADDR_LP_NP_LOW 16'h020B
`define APR_ADDR_LP_NP_MID 16'h020C
`define APR_ADDR_LP_NP_HIGH 16'h020D
`define APR_ADDR_CONTROL 16'h020E

// Reset values
`define APR_NP_LOW_RST 16'h2001
`define APR_ZERO16 16'h0000
`define APR_CONTROL_RST 16'h8000

// Implemented bits: partner base page words and local words
`define APR_LP_BASE_LOW_MASK 16'hFC1F
`define APR_LP_BASE_MID_MASK 16'h40F0
`define APR_LP_BASE_HIGH_MASK 16'h7800
`define APR_NP_LOW_WR_MASK 16'hB7FF
`define APR_CONTROL_WR_MASK 16'hB000

// Field positions
`define APR_NP_ACK_BIT 14
`define APR_STATUS_PAGE_RX_BIT 6

// Management frame fields
`define APR_DEVICE_ADDR 5'h07
`define APR_PREAMBLE_BITS 6'd32
`define APR_HDR_BITS 4'd13
`define APR_DATA_LAST 4'd15
`define APR_OP_ADDRESS 2'b00
`define APR_OP_WRITE 2'b01
`define APR_OP_READ_INC 2'b10

`endif

// ---- apr_mdio.v ----
// Purpose: Management frame engine: samples the serial clock and data, decodes
//          address, write, read and read-increment frames, drives read data
// Assumes: Serial clock far slower than ref_clk (at least 8 ref_clk per half)
// Notes: Read data is fetched one ref_clk after the header and shifted out
`timescale 1ns/100ps
`include "apr_defs.vh"

module apr_mdio #(
	parameter [4:0] PORT_ADDR = 5'h00
) (
	input wire ref_clk,
	input wire sys_rst,
	input wire mdc,
	input wire mdioIn,
	output reg mdioOut,
	output reg mdioOe,
	output reg [15:0] regAddr,
	output reg rdReq,
	input wire [15:0] rdData,
	output reg wrReq,
	output reg [15:0] wrData
);

	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_HDR = 4'b0010;
	localparam [3:0] ST_TA = 4'b0100;
	localparam [3:0] ST_DATA = 4'b1000;

	reg mdcMeta_q, mdc_q, mdcPrev_q;
	reg dioMeta_q, dio_q;
	reg [3:0] state_q;
	reg [5:0] ones_q;
	reg [3:0] cnt_q;
	reg [12:0] hdr_q;
	reg [1:0] op_q;
	reg [15:0] shift_q;
	wire rise;
	wire [12:0] hdrNext;

	assign rise = mdc_q & ~mdcPrev_q;
	assign hdrNext = {hdr_q[11:0], dio_q};

	// Two-stage synchronisers for clock and data pins
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			mdcMeta_q <= 1'b0;
			mdc_q <= 1'b0;
			mdcPrev_q <= 1'b0;
			dioMeta_q <= 1'b1;
			dio_q <= 1'b1;
		end else begin
			mdcMeta_q <= mdc;
			mdc_q <= mdcMeta_q;
			mdcPrev_q <= mdc_q;
			dioMeta_q <= mdioIn;
			dio_q <= dioMeta_q;
		end
	end

	// Frame state machine, advanced on each rising serial clock edge
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			state_q <= ST_IDLE;
			ones_q <= 6'd0;
			cnt_q <= 4'd0;
			hdr_q <= 13'h0000;
			op_q <= 2'b00;
			shift_q <= 16'h0000;
			regAddr <= 16'h0000;
			rdReq <= 1'b0;
			wrReq <= 1'b0;
			wrData <= 16'h0000;
			mdioOut <= 1'b1;
			mdioOe <= 1'b0;
		end else begin
			rdReq <= 1'b0;
			wrReq <= 1'b0;
			if (rise) begin
				case (state_q)
					ST_IDLE: begin
						if (dio_q) begin
							if (ones_q != `APR_PREAMBLE_BITS)
								ones_q <= ones_q + 6'd1;
						end else begin
							if (ones_q == `APR_PREAMBLE_BITS) begin
								state_q <= ST_HDR;
								cnt_q <= 4'd0;
							end
							ones_q <= 6'd0;
						end
					end
					ST_HDR: begin
						hdr_q <= hdrNext;
						cnt_q <= cnt_q + 4'd1;
						if (cnt_q == `APR_HDR_BITS - 4'd1) begin
							cnt_q <= 4'd0;
							// Second start bit 0, port and device must match
							if (!hdrNext[12] && hdrNext[9:5] == PORT_ADDR &&
								hdrNext[4:0] == `APR_DEVICE_ADDR) begin
								state_q <= ST_TA;
								op_q <= hdrNext[11:10];
								rdReq <= hdrNext[11];
							end else begin
								state_q <= ST_IDLE;
							end
						end
					end
					ST_TA: begin
						cnt_q <= cnt_q + 4'd1;
						if (cnt_q == 4'd0) begin
							mdioOe <= op_q[1];
							mdioOut <= 1'b0;
							shift_q <= rdData;
						end else begin
							mdioOut <= shift_q[15];
							shift_q <= {shift_q[14:0], 1'b0};
							state_q <= ST_DATA;
							cnt_q <= 4'd0;
						end
					end
					ST_DATA: begin
						cnt_q <= cnt_q + 4'd1;
						if (op_q[1]) begin
							mdioOut <= shift_q[15];
							shift_q <= {shift_q[14:0], 1'b0};
						end else begin
							shift_q <= {shift_q[14:0], dio_q};
						end
						if (cnt_q == `APR_DATA_LAST) begin
							state_q <= ST_IDLE;
							mdioOe <= 1'b0;
							mdioOut <= 1'b1;
							if (op_q == `APR_OP_ADDRESS)
								regAddr <= {shift_q[14:0], dio_q};
							if (op_q == `APR_OP_WRITE) begin
								wrReq <= 1'b1;
								wrData <= {shift_q[14:0], dio_q};
							end
							if (op_q == `APR_OP_READ_INC)
								regAddr <= regAddr + 16'h0001;
						end
					end
					default: begin
						state_q <= ST_IDLE;
						mdioOe <= 1'b0;
					end
				endcase
			end
		end
	end

endmodule

// ---- apr_bank_sva.sv ----
// Purpose: Port-level checks for the page register bank
// Assumes: Serial clock half period of at least 8 ref_clk
// Notes: Bound to apr_bank from the testbench top file
`timescale 1ns/100ps

module apr_bank_sva #(
	parameter [1:0] TX_LEVEL_STRAP = 2'b00
) (
	input wire ref_clk,
	input wire sys_rst,
	input wire mdc,
	input wire mdioOut,
	input wire mdioOe,
	input wire anRst,
	input wire txPageTaken,
	input wire [47:0] txPage,
	input wire txPageReady,
	input wire [3:0] advControl
);
	reg mdc_q;
	reg [4:0] riseCnt_q;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// Counts serial clock rises while the device drives the line
	always @(posedge ref_clk) begin
		mdc_q <= mdc;
		if (sys_rst || !mdioOe) begin
			riseCnt_q <= 5'h00;
		end else if (mdc && !mdc_q) begin
			riseCnt_q <= riseCnt_q + 5'h01;
		end
	end
	// Turnaround zero, then the device keeps the line
	sequence s_turnaround;
		!mdioOut ##1 mdioOe [*8];
	endsequence
	sequence s_reset_left;
		$fell(sys_rst);
	endsequence
	a_reset_outputs: assert property (s_reset_left |-> !mdioOe && mdioOut && !txPageReady &&
		txPage == 48'h000000002001 && advControl == {2'b10, TX_LEVEL_STRAP})
		else $error("outputs not at reset values");
	a_page_fixed_zero: assert property (txPage[14] == 1'b0 && txPage[11] == 1'b0)
		else $error("toggle or acknowledge bit set in page");
	a_anrst_restore: assert property (anRst |=> !txPageReady && txPage == 48'h000000002001)
		else $error("autoneg reset did not restore page");
	a_taken_clears: assert property (txPageTaken && !mdc |=> !txPageReady)
		else $error("page ready not cleared when taken");
	a_ready_by_write: assert property ($rose(txPageReady) |-> mdc)
		else $error("page ready rose outside a frame");
	a_page_frozen: assert property ($changed(txPage) && !$past(sys_rst) |-> mdc || $past(anRst))
		else $error("page changed without write or reset");
	a_control_by_write: assert property ($changed(advControl) && !$past(sys_rst) |-> mdc)
		else $error("control changed outside a frame");
	a_turnaround_low: assert property ($rose(mdioOe) |-> s_turnaround)
		else $error("turnaround bit not driven low");
	a_read_length: assert property ($fell(mdioOe) && !$past(sys_rst) |-> riseCnt_q == 5'h11)
		else $error("read drive length wrong");
	a_drive_on_high: assert property (($changed(mdioOut) || $changed(mdioOe)) && !$past(sys_rst) |-> mdc)
		else $error("data line changed while clock low");
endmodule

// ---- apr_host.sv ----
// Purpose: Station management host making serial frames
// Assumes: Line has a pull-up; 16 ref_clk per serial bit
// Notes: Serial clock stands low between frames
`timescale 1ns/100ps
`include "apr_defs.vh"

module apr_host (
	input wire ref_clk,
	input wire mdioOut,
	input wire mdioOe,
	output reg mdc,
	output wire mdioLine
);
	reg hostOe;
	reg hostBit;
	// Line level: device, else host, else the pull-up
	assign mdioLine = mdioOe ? mdioOut : (hostOe ? hostBit : 1'b1);
	initial begin
		mdc = 1'b0;
		hostOe = 1'b0;
		hostBit = 1'b1;
	end
	// One whole frame; read data taken at each rising clock
	task xfer(input [1:0] op, input [15:0] dat, output [15:0] got);
		reg [63:0] frame;
		integer i;
		begin
			frame = {32'hFFFFFFFF, 2'b00, op, 5'h00, `APR_DEVICE_ADDR, 2'b10, dat};
			got = 16'h0000;
			for (i = 63; i >= 0; i = i - 1) begin
				@(posedge ref_clk);
				mdc <= 1'b0;
				// Both read kinds release the line from the first turnaround bit on
				hostOe <= !op[1] || (i > 17);
				hostBit <= frame[i];
				repeat (8) @(posedge ref_clk);
				mdc <= 1'b1;
				if (i < 16) got[i] = mdioLine;
				repeat (7) @(posedge ref_clk);
			end
			@(posedge ref_clk);
			mdc <= 1'b0;
			hostOe <= 1'b0;
		end
	endtask
endmodule

// ---- test_apr_bank.sv ----
// Purpose: Register-level test of the page register bank
// Assumes: Port address 0, strap 0
// Notes: All register traffic goes through management frames
`timescale 1ns/100ps
`include "apr_defs.vh"

module test_apr_bank;
	reg ref_clk;
	reg sys_rst;
	reg anRst;
	reg rxBaseValid;
	reg [47:0] rxBasePage;
	reg rxNextValid;
	reg [47:0] rxNextPage;
	reg localAck;
	reg txPageTaken;
	wire mdc;
	wire mdioLine;
	wire mdioOut;
	wire mdioOe;
	wire [47:0] txPage;
	wire txPageReady;
	wire [3:0] advControl;
	integer mismatches;
	integer comparisons;
	integer k;
	apr_bank dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .mdc(mdc), .mdioIn(mdioLine), .mdioOut(mdioOut),
		.mdioOe(mdioOe), .anRst(anRst), .rxBaseValid(rxBaseValid), .rxBasePage(rxBasePage),
		.rxNextValid(rxNextValid), .rxNextPage(rxNextPage), .localAck(localAck), .txPageTaken(txPageTaken),
		.txPage(txPage), .txPageReady(txPageReady), .advControl(advControl));
	apr_host host (.ref_clk(ref_clk), .mdioOut(mdioOut), .mdioOe(mdioOe), .mdc(mdc), .mdioLine(mdioLine));
	// Clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task end_of_test;
		begin
			if (mismatches == 0 && comparisons > 0) begin
				$display("RESULT: PASS");
			end else begin
				$display("RESULT: FAIL");
			end
			$finish;
		end
	endtask
	task chk(input [48:0] got, input [48:0] exp);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				mismatches = mismatches + 1;
				$display("BAD %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [15:0] a, input [15:0] d);
		reg [15:0] unused;
		begin
			host.xfer(`APR_OP_ADDRESS, a, unused);
			host.xfer(`APR_OP_WRITE, d, unused);
		end
	endtask
	task rdChk(input [15:0] a, input [15:0] e);
		reg [15:0] v;
		begin
			host.xfer(`APR_OP_ADDRESS, a, v);
			host.xfer(2'b11, 16'h0000, v);
			chk({33'h0, v}, {33'h0, e});
		end
	endtask
	// Address frame, read-then-increment frame, then a plain read of the next word
	task rdIncChk(input [15:0] a, input [15:0] e0, input [15:0] e1);
		reg [15:0] v;
		begin
			host.xfer(`APR_OP_ADDRESS, a, v);
			host.xfer(`APR_OP_READ_INC, 16'h0000, v);
			chk({33'h0, v}, {33'h0, e0});
			host.xfer(2'b11, 16'h0000, v);
			chk({33'h0, v}, {33'h0, e1});
		end
	endtask
	// One-cycle strobe of {anRst, rxBaseValid, rxNextValid, txPageTaken}
	task strobe(input [3:0] sel);
		begin
			@(posedge ref_clk);
			{anRst, rxBaseValid, rxNextValid, txPageTaken} <= sel;
			@(posedge ref_clk);
			{anRst, rxBaseValid, rxNextValid, txPageTaken} <= 4'h0;
			@(posedge ref_clk);
		end
	endtask
	// Watchdog
	initial begin
		#800000;
		mismatches = mismatches + 1;
		end_of_test;
	end
	// Main sequence
	initial begin
		mismatches = 0;
		comparisons = 0;
		sys_rst = 1'b1;
		{anRst, rxBaseValid, rxNextValid, txPageTaken, localAck} = 5'h00;
		rxBasePage = 48'h000000000000;
		rxNextPage = 48'h000000000000;
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rdChk(`APR_ADDR_NP_LOW, 16'h2001);
		rdChk(`APR_ADDR_CONTROL, 16'h8000);
		chk({txPageReady, txPage}, {1'b0, 48'h000000002001});
		// Local page: upper words first, then the low word
		wr(`APR_ADDR_NP_MID, 16'hA5C3);
		wr(`APR_ADDR_NP_HIGH, 16'h3C5A);
		wr(`APR_ADDR_NP_LOW, 16'hFFFF);
		chk({txPageReady, txPage}, {1'b1, 48'h3C5AA5C3B7FF});
		rdChk(`APR_ADDR_NP_LOW, 16'hB7FF);
		rdChk(`APR_ADDR_NP_MID, 16'hA5C3);
		strobe(4'h1);
		chk({txPageReady, txPage}, {1'b0, 48'h3C5AA5C3B7FF});
		// Codes 1, 5, 6 with second acknowledge, ack shown by the arbiter
		localAck <= 1'b1;
		for (k = 0; k < 3; k = k + 1) begin
			wr(`APR_ADDR_NP_LOW, 16'h3000 | ((k == 0) ? 16'h0001 : 16'h0004 + k[15:0]));
			rdChk(`APR_ADDR_NP_LOW, 16'h7000 | ((k == 0) ? 16'h0001 : 16'h0004 + k[15:0]));
		end
		localAck <= 1'b0;
		strobe(4'h8);
		chk({txPageReady, txPage}, {1'b0, 48'h000000002001});
		rdChk(`APR_ADDR_NP_MID, 16'h0000);
		// Partner base page, flag and latch on low-word read
		rxBasePage <= 48'hFFFFFFFFFFFF;
		strobe(4'h4);
		rdChk(`APR_ADDR_STATUS, 16'h0040);
		rdChk(`APR_ADDR_STATUS, 16'h0000);
		rdChk(`APR_ADDR_LP_BASE_LOW, 16'hFC1F);
		rxBasePage <= 48'h000000000000;
		strobe(4'h4);
		rdChk(`APR_ADDR_LP_BASE_MID, 16'h40F0);
		rdChk(`APR_ADDR_LP_BASE_HIGH, 16'h7800);
		// Partner next page, latch on low-word read
		rxNextPage <= 48'h12345678F9AB;
		strobe(4'h2);
		rdChk(`APR_ADDR_LP_NP_LOW, 16'hF9AB);
		rxNextPage <= 48'h000000000000;
		strobe(4'h2);
		rdChk(`APR_ADDR_LP_NP_MID, 16'h5678);
		rdChk(`APR_ADDR_LP_NP_HIGH, 16'h1234);
		// Read-then-increment walks from the middle copy to the upper copy
		rdIncChk(`APR_ADDR_LP_NP_MID, 16'h5678, 16'h1234);
		// Read-only write ignored, unmapped read, control word
		wr(`APR_ADDR_LP_NP_LOW, 16'hFFFF);
		rdChk(`APR_ADDR_LP_NP_LOW, 16'h0000);
		rdChk(16'h0300, 16'h0000);
		wr(`APR_ADDR_CONTROL, 16'hFFFF);
		rdChk(`APR_ADDR_CONTROL, 16'hB000);
		chk({45'h0, advControl}, {45'h0, 4'hB});
		end_of_test;
	end
endmodule

bind apr_bank apr_bank_sva #(.TX_LEVEL_STRAP(TX_LEVEL_STRAP)) chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.mdc(mdc), .mdioOut(mdioOut), .mdioOe(mdioOe), .anRst(anRst), .txPageTaken(txPageTaken),
	.txPage(txPage), .txPageReady(txPageReady), .advControl(advControl));
